// >>> verilog/serial_baud_rate_generator.sv
// Module: baud rate generator with APB registers and majority-vote receive sampling
// Notes on behaviour
// (RULE1) Receive level is majority of three samples
// (RULE2) Async 8-bit low speed divides by 64(n+1)
// (RULE3) Async high 8-bit or low 16-bit: 16(n+1)
// (RULE4) Sync mode divides by 4(n+1), ignores speed
// (RULE5) Divisor is high byte above low byte
// (RULE6) Software reprograms divisor after clock change
// (RULE7) Narrow mode uses low byte only
// (RULE8) Divisor write resets the timer at once
// (RULE9) Sync slave takes bit clock from pin
// (RULE10) Async 16-bit high speed divides by 4(n+1)
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module serial_baud_rate_generator
  import rate_gen_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire apb_req_t    apb_req,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Pins from outside
  input  wire logic        receive_pin,
  input  wire logic        ext_clock_pin,
  // To the shift logic
  output logic             bit_tick,
  output logic             sample_tick,
  output logic             receive_level
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0]  transmit_status_control;  // Mode, speed, clock source
  logic [7:0]  receive_status_control;   // Port enable
  logic [7:0]  rate_control;             // Divisor width
  logic [7:0]  rate_divisor_high;        // Upper divisor byte
  logic [7:0]  rate_divisor_low;         // Lower divisor byte
  logic [7:0]  next_tsc, next_rsc, next_rc, next_dh, next_dl;
  logic        next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic        divisor_write;            // Pulse on any divisor write

  wire access  = apb_req.psel && apb_req.penable && !pready;
  wire do_wr   = access && apb_req.pwrite;

  // Address decode used by both read and write paths
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == ADDR_TRANSMIT_STATUS_CONTROL) || (a == ADDR_RECEIVE_STATUS_CONTROL) ||
                 (a == ADDR_RATE_CONTROL) || (a == ADDR_RATE_DIVISOR_HIGH) ||
                 (a == ADDR_RATE_DIVISOR_LOW) || (a == ADDR_RATE_STATUS);
  endfunction

  wire sync_mode   = transmit_status_control[BIT_SYNC_MODE];
  wire high_speed  = transmit_status_control[BIT_HIGH_SPEED_SCALING];
  wire master      = transmit_status_control[BIT_CLOCK_SOURCE_MASTER];
  wire wide        = rate_control[BIT_WIDE_DIVISOR_ENABLE];
  wire port_on     = receive_status_control[BIT_PORT_ENABLE];

  // Bus next-state: one wait state, answer registered
  always_comb begin
    next_tsc     = transmit_status_control;
    next_rsc     = receive_status_control;
    next_rc      = rate_control;
    next_dh      = rate_divisor_high;
    next_dl      = rate_divisor_low;
    next_pready  = access;
    next_pslverr = access && !addr_known(apb_req.paddr);
    next_prdata  = READ_ZERO;
    divisor_write = 1'b0;
    if (do_wr) begin
      case (apb_req.paddr)
        ADDR_TRANSMIT_STATUS_CONTROL: next_tsc = apb_req.pwdata[7:0] & MASK_TRANSMIT_STATUS_CONTROL;
        ADDR_RECEIVE_STATUS_CONTROL:  next_rsc = apb_req.pwdata[7:0] & MASK_RECEIVE_STATUS_CONTROL;
        ADDR_RATE_CONTROL:            next_rc  = apb_req.pwdata[7:0] & MASK_RATE_CONTROL;
        ADDR_RATE_DIVISOR_HIGH: begin
          next_dh       = apb_req.pwdata[7:0];
          divisor_write = 1'b1;  // RULE8
        end
        ADDR_RATE_DIVISOR_LOW: begin
          next_dl       = apb_req.pwdata[7:0];
          divisor_write = 1'b1;  // RULE8
        end
        default: next_dl = rate_divisor_low;  // Read-only or unmapped
      endcase
    end else if (access) begin
      case (apb_req.paddr)
        ADDR_TRANSMIT_STATUS_CONTROL: next_prdata = {24'h000000, transmit_status_control};
        ADDR_RECEIVE_STATUS_CONTROL:  next_prdata = {24'h000000, receive_status_control};
        ADDR_RATE_CONTROL:            next_prdata = {24'h000000, rate_control};
        ADDR_RATE_DIVISOR_HIGH:       next_prdata = {24'h000000, rate_divisor_high};
        ADDR_RATE_DIVISOR_LOW:        next_prdata = {24'h000000, rate_divisor_low};
        ADDR_RATE_STATUS:             next_prdata = {29'h00000000, receive_level, bit_tick, port_on};
        default:                      next_prdata = READ_ZERO;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_status_control <= RESET_BYTE;
      receive_status_control  <= RESET_BYTE;
      rate_control            <= RESET_BYTE;
      rate_divisor_high       <= RESET_BYTE;
      rate_divisor_low        <= RESET_BYTE;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      prdata                  <= READ_ZERO;
    end else if (clk_en) begin
      transmit_status_control <= next_tsc;
      receive_status_control  <= next_rsc;
      rate_control            <= next_rc;
      rate_divisor_high       <= next_dh;
      rate_divisor_low        <= next_dl;
      pready                  <= next_pready;
      pslverr                 <= next_pslverr;
      prdata                  <= next_prdata;
    end
  end

  // ****************************************************************
  // Pin synchronisers and majority vote
  // ****************************************************************
  logic [1:0] rx_sync, ck_sync;   // Two-flop synchronisers
  logic [2:0] rx_hist;            // Last three synchronised samples
  logic       ck_prev;
  logic [1:0] next_rx_sync, next_ck_sync;
  logic [2:0] next_rx_hist;
  logic       next_level;

  // Majority of three, used for the vote and its check
  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Samples are taken at each sample tick so the vote spans three ticks
  always_comb begin
    next_rx_sync = {rx_sync[0], receive_pin};
    next_ck_sync = {ck_sync[0], ext_clock_pin};
    next_rx_hist = sample_tick ? {rx_hist[1:0], rx_sync[1]} : rx_hist;
    next_level   = majority3(rx_hist);  // RULE1
  end

  // Sampling registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync       <= 2'h3;
      ck_sync       <= 2'h0;
      rx_hist       <= 3'h7;
      ck_prev       <= 1'b0;
      receive_level <= 1'b1;
    end else if (clk_en) begin
      rx_sync       <= next_rx_sync;
      ck_sync       <= next_ck_sync;
      rx_hist       <= next_rx_hist;
      ck_prev       <= ck_sync[1];
      receive_level <= next_level;
    end
  end

  // ****************************************************************
  // Divisor timer and scaler
  // ****************************************************************
  scale_t      scale;
  logic [15:0] divisor;
  logic [15:0] count, next_count;
  logic [5:0]  pre, next_pre, pre_max;
  logic        next_bit_tick, next_sample_tick;

  // Divisor as the timer sees it; narrow mode drops the high byte
  function automatic logic [15:0] pick_divisor(input logic w, input logic [7:0] hi, input logic [7:0] lo);
    pick_divisor = w ? {hi, lo} : {8'h00, lo};  // RULE5 RULE7
  endfunction

  // Scaling choice; divisor is n, period is scale*(n+1) clocks
  always_comb begin
    divisor = pick_divisor(wide, rate_divisor_high, rate_divisor_low);  // RULE5 RULE7
    if (sync_mode)
      scale = SCALE_4;                                      // RULE4
    else if (!wide && !high_speed)
      scale = SCALE_64;                                     // RULE2
    else if (wide && high_speed)
      scale = SCALE_4;                                      // RULE10
    else
      scale = SCALE_16;                                     // RULE3
    case (scale)
      SCALE_64: pre_max = PRESCALE_DIV64;
      SCALE_16: pre_max = PRESCALE_DIV16;
      SCALE_4:  pre_max = PRESCALE_DIV4;
      default:  pre_max = PRESCALE_DIV64;
    endcase
  end

  // Timer counts n..0 once per clock, scaler counts timer expiries
  always_comb begin
    next_count       = count;
    next_pre         = pre;
    next_sample_tick = 1'b0;
    next_bit_tick    = 1'b0;
    if (!port_on || divisor_write) begin
      // Bytes are taken as they are written, so the first period already runs at the new rate
      next_count = pick_divisor(wide, next_dh, next_dl);  // RULE8
      next_pre   = 6'h00;
    end else if (sync_mode && !master) begin
      next_bit_tick    = ck_sync[1] && !ck_prev;  // RULE9
      next_sample_tick = next_bit_tick;
    end else if (count == RESET_COUNT) begin
      next_count       = divisor;
      next_sample_tick = 1'b1;
      if (pre >= pre_max) begin
        next_pre      = 6'h00;
        next_bit_tick = 1'b1;
      end else begin
        next_pre = pre + 6'h01;
      end
    end else begin
      next_count = count - 16'h0001;
    end
  end

  // Timer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count       <= RESET_COUNT;
      pre         <= 6'h00;
      bit_tick    <= 1'b0;
      sample_tick <= 1'b0;
    end else if (clk_en) begin
      count       <= next_count;
      pre         <= next_pre;
      bit_tick    <= next_bit_tick;
      sample_tick <= next_sample_tick;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence div_write_s;
    clk_en && do_wr && (apb_req.paddr == ADDR_RATE_DIVISOR_LOW || apb_req.paddr == ADDR_RATE_DIVISOR_HIGH);
  endsequence

  timer_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    div_write_s |=> (count == divisor)) else $error("timer not reloaded on divisor write");  // RULE8

  vote_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> (receive_level == majority3($past(rx_hist)))) else $error("bad majority vote");  // RULE1

  narrow_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wide |-> divisor[15:8] == 8'h00) else $error("high byte used in narrow mode");  // RULE7

  wide_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    wide |-> divisor == {rate_divisor_high, rate_divisor_low}) else $error("wide divisor wrong");  // RULE5

  scale64_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!sync_mode && !wide && !high_speed) |-> pre_max == PRESCALE_DIV64) else $error("scale not 64");  // RULE2

  scale16_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!sync_mode && (wide != high_speed)) |-> pre_max == PRESCALE_DIV16) else $error("scale not 16");  // RULE3

  scale4_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_mode || (wide && high_speed)) |-> pre_max == PRESCALE_DIV4) else $error("scale not 4");  // RULE4

  slave_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && port_on && sync_mode && !master && !divisor_write && ck_sync[1] && !ck_prev)
    |=> bit_tick) else $error("slave clock edge missed");  // RULE9

endmodule

// >>> verilog/rate_gen_pkg.sv
// Package: register map, field positions, reset values and mode types for the rate generator
package rate_gen_pkg;

  // ****************************************************************
  // Register byte addresses (aligned words on APB)
  // ****************************************************************
  localparam logic [7:0] ADDR_TRANSMIT_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RECEIVE_STATUS_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_RATE_CONTROL            = 8'h08;
  localparam logic [7:0] ADDR_RATE_DIVISOR_HIGH       = 8'h0C;
  localparam logic [7:0] ADDR_RATE_DIVISOR_LOW        = 8'h10;
  localparam logic [7:0] ADDR_RATE_STATUS             = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_CLOCK_SOURCE_MASTER = 7;  // Transmit control
  localparam int BIT_SYNC_MODE           = 4;  // Transmit control
  localparam int BIT_HIGH_SPEED_SCALING  = 2;  // Transmit control
  localparam int BIT_PORT_ENABLE         = 7;  // Receive control
  localparam int BIT_WIDE_DIVISOR_ENABLE = 3;  // Rate control

  // Writable masks; other bits read as zero
  localparam logic [7:0] MASK_TRANSMIT_STATUS_CONTROL = 8'h94;
  localparam logic [7:0] MASK_RECEIVE_STATUS_CONTROL  = 8'h80;
  localparam logic [7:0] MASK_RATE_CONTROL            = 8'h08;

  // ****************************************************************
  // Reset values and scaling counts
  // ****************************************************************
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [15:0] RESET_COUNT     = 16'h0000;
  localparam logic [5:0]  PRESCALE_DIV64  = 6'h3F;  // 64 - 1
  localparam logic [5:0]  PRESCALE_DIV16  = 6'h0F;  // 16 - 1
  localparam logic [5:0]  PRESCALE_DIV4   = 6'h03;  // 4 - 1
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

  // Scaling mode of the generator
  typedef enum logic [1:0] {
    SCALE_64,
    SCALE_16,
    SCALE_4
  } scale_t;

  // APB request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// >>> testbench/shift_partner.sv
// Partner model of the shift logic that consumes the rate ticks
`timescale 1ns/100ps
module shift_partner (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Tick from the generator
  input  wire logic        bit_tick,
  // Measured interval and tick count
  output logic [15:0]      period,
  output logic [15:0]      ticks
);
  // ****************************************************************
  // Tick interval measurement
  // ****************************************************************
  logic [15:0] gap;  // Clocks since the last tick

  // The shift logic moves one bit per tick, so the gap is the bit time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 16'h0001;
      period <= 16'h0000;
      ticks <= 16'h0000;
    end else if (bit_tick) begin
      period <= gap;
      gap <= 16'h0001;
      ticks <= ticks + 16'h0001;
    end else begin
      gap <= gap + 16'h0001;
    end
  end
endmodule

// >>> testbench/serial_baud_rate_generator_tb.sv
// Testbench: register bus, rate modes, timer reload, sampling and slave clock
`timescale 1ns/100ps
module serial_baud_rate_generator_tb;
  import rate_gen_pkg::*;
  logic        pclk = 1'b0;      // Bus clock, 5 ns
  logic        presetn = 1'b0;   // Reset, active low
  apb_req_t    req = '0;         // APB request
  logic        pready;           // Bus answer
  logic [31:0] prdata;           // Read data
  logic        pslverr;          // Error answer
  logic        rx = 1'b1;        // Receive line, idle high
  logic        ext_clk = 1'b0;   // External bit clock
  logic        ext_run = 1'b0;   // Let the external clock run
  logic        clk_en = 1'b1;    // Clock enable, lowered in one scenario
  logic        bit_tick;         // Bit rate pulse
  logic        sample_tick;      // Sampling pulse
  logic        receive_level;    // Voted line level
  logic [15:0] period;           // Measured tick gap
  logic [15:0] ticks;            // Tick count
  logic [31:0] rd;               // Last read data
  logic        er;               // Last error flag
  int          bad_count = 0;    // Mismatches
  int          cmp_count = 0;    // Comparisons
  int          cyc = 0;          // Cycle count for the timeout

  always #2.5 pclk = ~pclk;

  serial_baud_rate_generator serial_baud_rate_generator_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .receive_pin(rx),
    .ext_clock_pin(ext_clk), .bit_tick(bit_tick), .sample_tick(sample_tick), .receive_level(receive_level));
  shift_partner shift_partner_i (.pclk(pclk), .presetn(presetn), .bit_tick(bit_tick), .period(period),
    .ticks(ticks));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // External clock toggles every 10 cycles while enabled, 20-cycle period
  always @(posedge pclk) begin
    if (ext_run && (cyc % 10 == 0)) begin
      ext_clk <= ~ext_clk;
    end
  end

  // A hang is cut short here; the tests need about 14000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Pready is read just after the edge, which is the value that edge sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h000000, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask

  // Waits for a count of further ticks, then for settled values
  // Counts are read on the falling edge, where the partner's registers have settled
  task automatic wait_ticks(input int k);
    logic [15:0] s;
    @(negedge pclk);
    s = ticks;
    while (ticks < s + k) @(negedge pclk);
  endtask

  task automatic mode(input logic [7:0] tx, input logic [7:0] wide, input logic [7:0] hi, input logic [7:0] lo,
                      input logic [15:0] exp);
    apb(1'b1, ADDR_RATE_CONTROL, wide);
    apb(1'b1, ADDR_RATE_DIVISOR_HIGH, hi);
    apb(1'b1, ADDR_RATE_DIVISOR_LOW, lo);
    apb(1'b1, ADDR_TRANSMIT_STATUS_CONTROL, tx);
    wait_ticks(2);
    check({16'h0000, period}, {16'h0000, exp});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_values();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 8'h00);
      check(rd, (i == 5) ? 32'h0000_0004 : READ_ZERO);
    end
    apb(1'b0, 8'h18, 8'h00);
    check({31'h0, er}, 32'h0000_0001);
    apb(1'b1, ADDR_RATE_CONTROL, 8'hFF);
    apb(1'b0, ADDR_RATE_CONTROL, 8'h00);
    check(rd, 32'h0000_0008);
  endtask

  task automatic rate_modes();
    apb(1'b1, ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
    mode(8'h00, 8'h00, 8'h05, 8'h02, 16'd192);
    mode(8'h04, 8'h00, 8'h05, 8'h02, 16'd48);
    mode(8'h00, 8'h08, 8'h01, 8'h02, 16'd4144);
    mode(8'h04, 8'h08, 8'h01, 8'h02, 16'd1036);
    mode(8'h94, 8'h00, 8'h05, 8'h02, 16'd12);
    mode(8'h90, 8'h08, 8'h01, 8'h02, 16'd1036);
  endtask

  // A new divisor after a clock change must act without the old count expiring
  task automatic timer_reload();
    int n;
    mode(8'h80, 8'h00, 8'h00, 8'h01, 16'd128);
    apb(1'b1, ADDR_RATE_DIVISOR_LOW, 8'hFF);
    repeat (200) @(posedge pclk);
    apb(1'b1, ADDR_RATE_DIVISOR_LOW, 8'h00);
    n = 0;
    while (bit_tick !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, n <= 70}, 32'h0000_0001);
    wait_ticks(1);
    check({16'h0000, period}, 32'd64);
  endtask

  // A glitch one sample period long reaches exactly one of three samples
  task automatic majority();
    int hits;
    mode(8'h90, 8'h00, 8'h00, 8'h03, 16'd16);
    @(posedge pclk);
    rx <= 1'b0;
    repeat (40) @(posedge pclk);
    check({31'h0, receive_level}, 32'h0);
    rx <= 1'b1;
    repeat (4) @(posedge pclk);
    rx <= 1'b0;
    hits = 0;
    repeat (40) begin
      @(posedge pclk);
      hits = hits + receive_level;
    end
    check(32'(hits), 32'h0);
    rx <= 1'b1;
    repeat (40) @(posedge pclk);
    check({31'h0, receive_level}, 32'h1);
    hits = 0;
    repeat (16) begin
      @(posedge pclk);
      hits = hits + sample_tick;
    end
    check(32'(hits), 32'd4);
  endtask

  // Low clock enable holds every register, so no tick and no new sample appear
  task automatic freeze();
    logic [15:0] s;
    wait_ticks(1);
    s = ticks;
    @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    rx <= 1'b0;
    repeat (100) @(posedge pclk);
    check({16'h0000, ticks}, {16'h0000, s});
    check({31'h0, receive_level}, 32'h1);
    rx <= 1'b1;
    clk_en <= 1'b1;
    wait_ticks(2);
    check({16'h0000, period}, 32'd16);
  endtask

  task automatic slave_clock();
    apb(1'b1, ADDR_TRANSMIT_STATUS_CONTROL, 8'h10);
    ext_run <= 1'b1;
    wait_ticks(3);
    check({16'h0000, period}, 32'd20);
    ext_run <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    rate_modes();
    timer_reload();
    majority();
    freeze();
    slave_clock();
    conclude();
  end
endmodule
